// >>> rtl/axil_port.sv
// AXI4-Lite slave front end: turns channel handshakes into access strobes
`timescale 1ns/1ps
module axil_port
  import irq_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);
  // =====================================================================
  // Write path: address and data may arrive in either order
  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_en   = !bvalid_r && (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end
    else if (wr_en)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // =====================================================================
  // Read path: one cycle from address handshake to data
  assign s_axi_arready = !rvalid_r;
  assign rd_en   = s_axi_arvalid && !rvalid_r;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end
    else if (rd_en)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_err ? RESP_SLVERR : RESP_OKAY;
      rdata_r  <= rd_data;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;
endmodule : axil_port

// >>> rtl/event_sticky.sv
// Sticky event flags with clear-on-read; a set in the clear cycle survives
`timescale 1ns/1ps
module event_sticky
  import irq_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  output logic      [W-1:0] flags
);
  // =====================================================================
  // Flag storage
  logic [W-1:0] flags_r;

  initial
  begin
    if (W < 1)
      $error("event_sticky: width must be positive");
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_r <= '0;
    else if (clr)
      flags_r <= set;
    else
      flags_r <= flags_r | set;
  end

  assign flags = flags_r;
endmodule : event_sticky

// >>> rtl/irq_flags_top.sv
// Interrupt flags, masks and interrupt output of the reader front end
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module irq_flags_top
  import irq_pkg::*;
#(
  parameter int COUNT_W  = 10,
  parameter int RX_LEVEL = 300,
  parameter int TX_LEVEL = 200
)
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               osc_enable,
  input  wire logic               osc_stable,
  input  wire logic               rx_active,
  input  wire logic               tx_active,
  input  wire logic [COUNT_W-1:0] fifo_count,
  input  wire logic               field_above,
  input  wire logic               target_mode,
  input  wire logic               wake_every_timeout,
  input  wire main_evt_t          main_evt,
  input  wire timer_evt_t         timer_evt,
  input  wire err_evt_t           err_evt,
  input  wire logic [7:0]         main_mask,
  input  wire logic [7:0]         timer_mask,
  input  wire logic [7:0]         pt_flags,
  output logic [7:0]              error_wake_mask,
  output logic [7:0]              passive_target_mask,
  output logic                    irq
);
  // =====================================================================
  // Elaboration checks
  initial
  begin
    if (COUNT_W < 2 || COUNT_W > 16)
      $error("irq_flags_top: COUNT_W out of range");
    if (RX_LEVEL >= (1 << COUNT_W) || TX_LEVEL < 1)
      $error("irq_flags_top: FIFO levels do not fit the count");
  end

  localparam logic [COUNT_W-1:0] RX_LVL = COUNT_W'(RX_LEVEL);
  localparam logic [COUNT_W-1:0] TX_LVL = COUNT_W'(TX_LEVEL);

  // =====================================================================
  // Address decode
  typedef enum {
    SEL_NONE,
    SEL_EW_MASK,
    SEL_PT_MASK,
    SEL_MAIN,
    SEL_TIMER,
    SEL_ERR
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_ERR_WAKE_MASK))
        sel = SEL_EW_MASK;
      else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_PT_MASK))
        sel = SEL_PT_MASK;
      else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_MAIN_STATUS))
        sel = SEL_MAIN;
      else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_TIMER_STATUS))
        sel = SEL_TIMER;
      else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_ERR_STATUS))
        sel = SEL_ERR;
    end
    return sel;
  endfunction : decode

  // =====================================================================
  // Bus front end
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;
  reg_sel_t          wr_sel;
  reg_sel_t          rd_sel;

  axil_port u_port (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  assign wr_sel = decode(wr_addr);
  assign rd_sel = decode(rd_addr);
  assign wr_err = (wr_sel == SEL_NONE);
  assign rd_err = (rd_sel == SEL_NONE);

  // =====================================================================
  // Mask registers
  logic [7:0] ew_mask_r;
  logic [7:0] pt_mask_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ew_mask_r <= MASK_RESET;
    else if (wr_en && wr_strb[0] && wr_sel == SEL_EW_MASK)
      ew_mask_r <= wr_data[7:0] & ERR_WAKE_MASK_BITS;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pt_mask_r <= MASK_RESET;
    else if (wr_en && wr_strb[0] && wr_sel == SEL_PT_MASK)
      pt_mask_r <= wr_data[7:0] & PT_MASK_BITS;
  end

  assign error_wake_mask     = ew_mask_r;
  assign passive_target_mask = pt_mask_r;

  // =====================================================================
  // Level inputs turned into one-cycle events
  logic osc_prev_r;
  logic level_prev_r;
  logic field_prev_r;
  logic level_cond;
  logic osc_set;
  logic level_set;
  logic field_rise;
  logic field_drop;

  // Both directions can hold at once only if the unit reports both
  assign level_cond = (rx_active && fifo_count > RX_LVL)
                   || (tx_active && fifo_count < TX_LVL);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_prev_r   <= 1'b0;
      level_prev_r <= 1'b0;
      field_prev_r <= 1'b0;
    end
    else
    begin
      osc_prev_r   <= osc_stable && osc_enable;
      level_prev_r <= level_cond;
      field_prev_r <= field_above;
    end
  end

  assign osc_set    = osc_enable && osc_stable && !osc_prev_r;
  assign level_set  = level_cond && !level_prev_r;
  assign field_rise = field_above && !field_prev_r;
  assign field_drop = !field_above && field_prev_r;

  // =====================================================================
  // Set vectors
  logic [7:0] main_set;
  logic [7:0] timer_set;
  logic [7:0] err_set;

  always_comb
  begin
    main_set            = '0;
    main_set[MAIN_OSC]  = osc_set;
    main_set[MAIN_WL]   = level_set;
    main_set[MAIN_RXS]  = main_evt.rx_start;
    main_set[MAIN_RXE]  = main_evt.rx_end;
    main_set[MAIN_TXE]  = main_evt.tx_end;
    main_set[MAIN_COL]  = main_evt.bit_collision;
    main_set[MAIN_REST] = main_evt.rx_restart;
  end

  always_comb
  begin
    timer_set           = '0;
    timer_set[TMR_DCT]  = timer_evt.cmd_done;
    timer_set[TMR_NRE]  = timer_evt.noresp_expired;
    timer_set[TMR_GPE]  = timer_evt.gp_expired;
    timer_set[TMR_EON]  = field_rise;
    timer_set[TMR_EOF]  = field_drop;
    timer_set[TMR_CAC]  = timer_evt.ca_collision;
    timer_set[TMR_CAT]  = timer_evt.guard_done;
    timer_set[TMR_NFCT] = target_mode && timer_evt.bitrate_found;
  end

  always_comb
  begin
    err_set           = '0;
    err_set[ERR_CRC]  = err_evt.crc_error;
    err_set[ERR_PAR]  = err_evt.parity_error;
    err_set[ERR_SOFT] = err_evt.soft_framing;
    err_set[ERR_HARD] = err_evt.hard_framing;
    err_set[ERR_WT]   = wake_every_timeout && err_evt.wake_timeout;
    err_set[ERR_WAM]  = err_evt.amp_wake;
    err_set[ERR_WPH]  = err_evt.phase_wake;
  end

  // =====================================================================
  // Status flags; an event in the read cycle stays for the next read
  logic [7:0] main_flags;
  logic [7:0] timer_flags;
  logic [7:0] err_flags;
  logic       main_clr;
  logic       timer_clr;
  logic       err_clr;

  assign main_clr  = rd_en && rd_sel == SEL_MAIN;
  assign timer_clr = rd_en && rd_sel == SEL_TIMER;
  assign err_clr   = rd_en && rd_sel == SEL_ERR;

  event_sticky #(.W(8)) u_main (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (main_set),
    .clr     (main_clr),
    .flags   (main_flags)
  );

  event_sticky #(.W(8)) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (timer_set),
    .clr     (timer_clr),
    .flags   (timer_flags)
  );

  event_sticky #(.W(8)) u_err (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (err_set),
    .clr     (err_clr),
    .flags   (err_flags)
  );

  // =====================================================================
  // Read multiplexer; value is captured before the clear lands
  always_comb
  begin
    rd_data = '0;
    unique case (rd_sel)
      SEL_EW_MASK: rd_data[7:0] = ew_mask_r;
      SEL_PT_MASK: rd_data[7:0] = pt_mask_r;
      SEL_MAIN:    rd_data[7:0] = main_flags;
      SEL_TIMER:   rd_data[7:0] = timer_flags;
      SEL_ERR:     rd_data[7:0] = err_flags;
      SEL_NONE:    rd_data = '0;
    endcase
  end

  // =====================================================================
  // Interrupt output; one cycle behind the flags
  logic       irq_r;
  logic [7:0] main_pend;
  logic [7:0] timer_pend;
  logic [7:0] err_pend;
  logic [7:0] pt_pend;

  // Masked flags still read back; only the line is gated
  // Reserved passive-target bit never pends
  assign main_pend  = main_flags & ~main_mask;
  assign timer_pend = timer_flags & ~timer_mask;
  assign err_pend   = err_flags & ~ew_mask_r;
  assign pt_pend    = pt_flags & ~pt_mask_r & PT_MASK_BITS;

  // Registered so the host sees a glitch-free line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |{main_pend, timer_pend, err_pend, pt_pend};
  end

  assign irq = irq_r;
endmodule : irq_flags_top

// >>> rtl/irq_pkg.sv
// Package: register map, field positions and event carriers of the interrupt block
package irq_pkg;
  // =====================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_ERR_WAKE_MASK  = 8'h18;
  localparam logic [7:0] IDX_PT_MASK        = 8'h19;
  localparam logic [7:0] IDX_MAIN_STATUS    = 8'h1A;
  localparam logic [7:0] IDX_TIMER_STATUS   = 8'h1B;
  localparam logic [7:0] IDX_ERR_STATUS     = 8'h1C;
  localparam int         ADDR_W             = 12;
  localparam logic [7:0] MASK_RESET         = 8'h00;
  localparam logic [7:0] STATUS_RESET       = 8'h00;
  localparam logic [7:0] ERR_WAKE_MASK_BITS = 8'hFE;
  localparam logic [7:0] PT_MASK_BITS       = 8'hFB;
  localparam logic [1:0] RESP_OKAY          = 2'h0;
  localparam logic [1:0] RESP_SLVERR        = 2'h2;
  // =====================================================================
  // Main status bit positions
  localparam int MAIN_OSC   = 7;
  localparam int MAIN_WL    = 6;
  localparam int MAIN_RXS   = 5;
  localparam int MAIN_RXE   = 4;
  localparam int MAIN_TXE   = 3;
  localparam int MAIN_COL   = 2;
  localparam int MAIN_REST  = 1;
  // Timer and field status bit positions
  localparam int TMR_DCT    = 7;
  localparam int TMR_NRE    = 6;
  localparam int TMR_GPE    = 5;
  localparam int TMR_EON    = 4;
  localparam int TMR_EOF    = 3;
  localparam int TMR_CAC    = 2;
  localparam int TMR_CAT    = 1;
  localparam int TMR_NFCT   = 0;
  // Error and wake-up status / mask bit positions
  localparam int ERR_CRC    = 7;
  localparam int ERR_PAR    = 6;
  localparam int ERR_SOFT   = 5;
  localparam int ERR_HARD   = 4;
  localparam int ERR_WT     = 3;
  localparam int ERR_WAM    = 2;
  localparam int ERR_WPH    = 1;
  // Passive-target mask bit positions
  localparam int PT_PPON2   = 7;
  localparam int PT_SLWL    = 6;
  localparam int PT_APON    = 5;
  localparam int PT_RXE     = 4;
  localparam int PT_FAST    = 3;
  localparam int PT_STAR    = 1;
  localparam int PT_ACT     = 0;
  // =====================================================================
  // Event carriers
  typedef struct packed {
    logic rx_start;
    logic rx_end;
    logic tx_end;
    logic bit_collision;
    logic rx_restart;
  } main_evt_t;

  typedef struct packed {
    logic cmd_done;
    logic noresp_expired;
    logic gp_expired;
    logic ca_collision;
    logic guard_done;
    logic bitrate_found;
  } timer_evt_t;

  typedef struct packed {
    logic crc_error;
    logic parity_error;
    logic soft_framing;
    logic hard_framing;
    logic wake_timeout;
    logic amp_wake;
    logic phase_wake;
  } err_evt_t;
endpackage : irq_pkg

// >>> sim/irq_flags_sva.sv
// Checker: mask, flag and interrupt timing of the interrupt block
`timescale 1ns/1ps
module irq_flags_sva
  import irq_pkg::*;
#(
  parameter int COUNT_W  = 10,
  parameter int RX_LEVEL = 300,
  parameter int TX_LEVEL = 200
)
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic [3:0]         s_axi_wstrb,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               osc_enable,
  input wire logic               osc_stable,
  input wire logic               rx_active,
  input wire logic               tx_active,
  input wire logic [COUNT_W-1:0] fifo_count,
  input wire logic               field_above,
  input wire logic               wake_every_timeout,
  input wire err_evt_t           err_evt,
  input wire logic [7:0]         main_mask,
  input wire logic [7:0]         timer_mask,
  input wire logic [7:0]         pt_flags,
  input wire logic [7:0]         error_wake_mask,
  input wire logic [7:0]         passive_target_mask,
  input wire logic               irq
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Steps
  sequence wr_at(a);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_wstrb[0] && s_axi_awaddr == a;
  endsequence
  sequence osc_up;
    $rose(osc_enable && osc_stable) && !main_mask[7];
  endsequence
  // ==========================================================
  // Properties
  mask_reset_a: assert property (
    $rose(aresetn) |-> error_wake_mask == 8'h00 && passive_target_mask == 8'h00 && !irq)
    else $error("masks or irq not clear after reset");
  mask_hide_a: assert property (
    error_wake_mask == 8'hFE && passive_target_mask == 8'hFB && main_mask == 8'hFF
      && timer_mask == 8'hFF && pt_flags == 8'h00 |=> !irq)
    else $error("irq while all masked");
  ew_mask_a: assert property (
    wr_at(12'h060) |=> error_wake_mask == ($past(s_axi_wdata[7:0]) & 8'hFE))
    else $error("error wake mask write wrong");
  pt_mask_a: assert property (
    wr_at(12'h064) |=> passive_target_mask == ($past(s_axi_wdata[7:0]) & 8'hFB))
    else $error("passive mask write wrong");
  osc_irq_a: assert property (osc_up |-> ##2 irq)
    else $error("no irq after clock stable");
  rx_level_a: assert property (
    $rose(rx_active && fifo_count > RX_LEVEL) && !main_mask[6] |-> ##2 irq)
    else $error("no irq on receive level");
  tx_level_a: assert property (
    $rose(tx_active && fifo_count < TX_LEVEL) && !main_mask[6] |=> ##1 irq)
    else $error("no irq on transmit level");
  field_edge_a: assert property (
    ($rose(field_above) && !timer_mask[4]) || ($fell(field_above) && !timer_mask[3])
      |-> ##2 irq)
    else $error("no irq on field edge");
  wake_irq_a: assert property (
    err_evt.wake_timeout && wake_every_timeout && !error_wake_mask[3] |-> ##2 irq)
    else $error("no irq on wake timeout");
endmodule : irq_flags_sva

bind irq_flags_top irq_flags_sva #(.COUNT_W(COUNT_W), .RX_LEVEL(RX_LEVEL), .TX_LEVEL(TX_LEVEL))
  chk_u (.*);

// >>> sim/irq_host.sv
// Host model: AXI4-Lite master that programs masks and reads flags
`timescale 1ns/1ps
module irq_host
  import irq_pkg::*;
(
  input  wire logic         aclk,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic              s_axi_awvalid,
  input  wire logic         s_axi_awready,
  output logic [31:0]       s_axi_wdata,
  output logic [3:0]        s_axi_wstrb,
  output logic              s_axi_wvalid,
  input  wire logic         s_axi_wready,
  input  wire logic [1:0]   s_axi_bresp,
  input  wire logic         s_axi_bvalid,
  output logic              s_axi_bready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic              s_axi_arvalid,
  input  wire logic         s_axi_arready,
  input  wire logic [31:0]  s_axi_rdata,
  input  wire logic [1:0]   s_axi_rresp,
  input  wire logic         s_axi_rvalid,
  output logic              s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ==========================================================
  // Bus cycles; address and data go out together
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h0, v};
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Read at once when asked; late reads risk stale error flags
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : irq_host

// >>> sim/tb_irq_flags_top.sv
// Testbench: mask, flag and interrupt scenarios of the interrupt block
`timescale 1ns/1ps
module tb_irq_flags_top
  import irq_pkg::*;
  ;
  logic              aclk, aresetn, osc_enable, osc_stable, rx_active, tx_active;
  logic              field_above, target_mode, wake_every_timeout, irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [9:0]        fifo_count;
  logic [7:0]        main_mask, timer_mask, pt_flags, error_wake_mask, passive_target_mask;
  main_evt_t         main_evt;
  timer_evt_t        timer_evt;
  err_evt_t          err_evt;
  int                mismatches, n_tests;

  irq_flags_top dut_u (.*);
  irq_host host_u (.*);

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;
  // ==========================================================
  // Checking helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    host_u.rd(a, d, r);
    chk("rdata", d, {24'h0, e});
    chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rchk
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [1:0] r;
    host_u.wr(a, v, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr
  task automatic lvl(input logic rx, input logic tx, input logic [9:0] c, input logic [7:0] e);
    @(posedge aclk);
    rx_active  <= rx;
    tx_active  <= tx;
    fifo_count <= c;
    repeat (3) @(posedge aclk);
    rchk(12'h068, e);
  endtask : lvl
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(12'h060, 8'h00);
    rchk(12'h064, 8'h00);
    wr(12'h060, 8'hFF);
    wr(12'h064, 8'hFF);
    wr(12'h068, 8'hFF);
    rchk(12'h060, 8'hFE);
    rchk(12'h064, 8'hFB);
    rchk(12'h068, 8'h00);
    host_u.rd(12'h100, d, r);
    chk("bad_rdata", d, 32'h0);
    chk("bad_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test regs done");
  endtask : t_regs
  task automatic t_hide;
    @(posedge aclk);
    main_mask  <= 8'hFF;
    timer_mask <= 8'hFF;
    err_evt    <= '1;
    @(posedge aclk);
    err_evt <= '0;
    repeat (3) @(posedge aclk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(12'h060, 8'h00);
    repeat (2) @(posedge aclk);
    chk("irq_unmasked", {31'h0, irq}, 32'h1);
    rchk(12'h070, 8'hF6);
    rchk(12'h070, 8'h00);
    repeat (2) @(posedge aclk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    pt_flags <= 8'h01;
    repeat (2) @(posedge aclk);
    chk("irq_pt_masked", {31'h0, irq}, 32'h0);
    wr(12'h064, 8'h00);
    repeat (2) @(posedge aclk);
    chk("irq_pt", {31'h0, irq}, 32'h1);
    pt_flags <= 8'h00;
    $display("test masking done");
  endtask : t_hide
  task automatic t_main;
    @(posedge aclk);
    main_mask  <= 8'h00;
    main_evt   <= '1;
    osc_enable <= 1'b1;
    osc_stable <= 1'b1;
    @(posedge aclk);
    main_evt <= '0;
    repeat (2) @(posedge aclk);
    rchk(12'h068, 8'hBE);
    rchk(12'h068, 8'h00);
    lvl(1'b1, 1'b0, 10'd300, 8'h00);
    lvl(1'b1, 1'b0, 10'd301, 8'h40);
    lvl(1'b0, 1'b1, 10'd200, 8'h00);
    lvl(1'b0, 1'b1, 10'd199, 8'h40);
    lvl(1'b0, 1'b0, 10'd0, 8'h00);
    $display("test main done");
  endtask : t_main
  task automatic t_timer;
    rchk(12'h06C, 8'h00);
    @(posedge aclk);
    timer_mask  <= 8'h00;
    timer_evt   <= '1;
    field_above <= 1'b1;
    @(posedge aclk);
    timer_evt <= '0;
    repeat (2) @(posedge aclk);
    rchk(12'h06C, 8'hF6);
    target_mode <= 1'b1;
    field_above <= 1'b0;
    timer_evt   <= 6'h01;
    @(posedge aclk);
    timer_evt <= '0;
    repeat (2) @(posedge aclk);
    rchk(12'h06C, 8'h09);
    rchk(12'h06C, 8'h00);
    $display("test timer done");
  endtask : t_timer
  task automatic t_wake;
    @(posedge aclk);
    wake_every_timeout <= 1'b1;
    err_evt            <= 7'h04;
    @(posedge aclk);
    err_evt <= '0;
    repeat (2) @(posedge aclk);
    rchk(12'h070, 8'h08);
    $display("test wake done");
  endtask : t_wake
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    {mismatches, n_tests} = '0;
    aresetn = 1'b0;
    {osc_enable, osc_stable, rx_active, tx_active, field_above, target_mode} = '0;
    {wake_every_timeout, fifo_count, main_mask, timer_mask, pt_flags} = '0;
    {main_evt, timer_evt, err_evt} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_hide();
    t_main();
    t_timer();
    t_wake();
    summarize();
  end
  // Whole run is under two hundred cycles; far beyond that means a stuck handshake
  initial
  begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    summarize();
  end
endmodule : tb_irq_flags_top
